// ===== hdl/fhc_codec.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fhc_codec
    import fhc_pkg::*;
(
    // Clock, reset, freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    fhc_regs_t q;
    fhc_regs_t d;
    logic [4:0] wfull;
    logic signed [39:0] lim;
    logic [31:0] conv_out;

    // ------------------------------------------------------------
    // One word of the block through the selected method
    // ------------------------------------------------------------
    function automatic logic [31:0] conv(
        input logic [15:0] x,
        input logic [1:0] m,
        input logic dec,
        input logic [4:0] w,
        input logic [7:0] p
    );
        logic signed [39:0] v;
        logic signed [39:0] lm;
        logic signed [39:0] k;
        logic signed [15:0] s;
        logic [4:0] sh;
        logic [16:0] a;
        logic [23:0] t;
        logic [23:0] off;
        logic [16:0] hq;
        logic [16:0] h3;
        logic [7:0] inv;
        logic neg;
        sh = FULL_WIDTH - w;
        s = $signed(x << sh) >>> sh;
        lm = 40'sd1 <<< (w - 5'd1);
        v = '0;
        k = '0;
        a = '0;
        t = '0;
        off = '0;
        inv = '0;
        neg = 1'b0;
        hq = (w >= 5'd2) ? (17'd1 << (w - 5'd2)) : 17'd0;
        h3 = hq + ((w >= 5'd3) ? (17'd1 << (w - 5'd3)) : 17'd0);
        case (m)
            METH_BFP: begin
                if (dec) begin
                    v = 40'(s) <<< p[3:0];
                end else begin
                    if (p[3:0] != 4'h0)
                        k = 40'sd1 <<< (p[3:0] - 4'h1);
                    v = (40'($signed(x)) + k) >>> p[3:0];
                end
            end
            METH_BS: begin
                if (dec) begin
                    v = $signed({32'h0, p}) * 40'(s);
                    if (w >= 5'd9) begin
                        if (w > 5'd9)
                            k = 40'sd1 <<< (w - 5'd10);
                        v = (v + k) >>> (w - 5'd9);
                    end else begin
                        v = v <<< (5'd9 - w);
                    end
                end else begin
                    inv = SCALE_UNITY / p;
                    v = $signed({32'h0, inv}) * 40'($signed(x));
                    if (sh != 5'd0)
                        v = (v + (40'sd1 <<< (sh - 5'd1))) >>> sh;
                end
            end
            default: begin
                if (dec) begin
                    neg = s[15];
                    a = neg ? 17'(-$signed({s[15], s})) : {1'b0, s};
                    if (a > 17'(lm - 40'sd1))
                        a = 17'(lm - 40'sd1);
                    k = 40'({23'h0, a}) <<< (5'd17 - w);
                    if (a <= hq)
                        k = k >>> 2;
                    else if (a <= h3)
                        k = (k >>> 1) - MU_SUB2;
                    else
                        k = k - MU_SUB3;
                    v = (neg ? -k : k) >>> p[3:0];
                end else begin
                    neg = x[15];
                    a = neg ? 17'({1'b0, ~x} + 17'd1) : {1'b0, x};
                    t = {7'h0, a} << p[3:0];
                    if (t > {7'h0, MAG_MAX})
                        t = {7'h0, MAG_MAX};
                    if (t <= {7'h0, MU_SEG1}) begin
                        t = t << 2;
                    end else if (t <= {7'h0, MU_SEG2}) begin
                        t = t << 1;
                        off = {7'h0, hq} >> 1;
                    end else begin
                        off = {7'h0, hq};
                    end
                    t = ((t >> (5'd16 - w)) + 24'd1) >> 1;
                    k = 40'({16'h0, t + off});
                    v = neg ? -k : k;
                end
            end
        endcase
        if (!dec && v > lm - 40'sd1)
            v = lm - 40'sd1;
        if (!dec && v < -lm)
            v = -lm;
        conv = v[31:0];
    endfunction : conv

    assign wfull = (q.width == 4'h0) ? FULL_WIDTH : {1'b0, q.width};
    assign lim = 40'sd1 <<< (wfull - 5'd1);
    assign conv_out = conv(q.ibuf[q.cnt], q.meth, q.decomp, wfull, q.param);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] x;
        logic [16:0] mabs;
        logic [15:0] mbs;
        logic [15:0] scale;
        logic [3:0] e;
        d = q;
        x = q.ibuf[q.cnt];
        mabs = '0;
        mbs = '0;
        scale = '0;
        e = '0;
        case (q.st)
            ST_SCAN: begin
                if ($signed(x) > $signed(q.maxv))
                    d.maxv = x;
                if ($signed(x) < $signed(q.minv))
                    d.minv = x;
                d.cnt = q.cnt + 5'd1;
                if (q.cnt == LAST_WORD) begin
                    d.st = ST_PARAM;
                    d.cnt = '0;
                end
            end
            ST_PARAM: begin
                if (!q.decomp) begin
                    case (q.meth)
                        METH_BFP: begin
                            for (int i = 15; i >= 0; i--) begin
                                if (40'($signed(q.maxv)) >>> i < lim
                                    && 40'($signed(q.minv)) >>> i >= -lim)
                                    e = 4'(i);
                            end
                            d.param = {4'h0, e};
                        end
                        METH_BS: begin
                            mbs = q.maxv[15] ? 16'h0 : q.maxv;
                            if (q.minv[15] && ~q.minv > mbs)
                                mbs = ~q.minv;
                            scale = (mbs + SCALE_ROUND) >> SCALE_SHIFT;
                            if (scale == 16'h0)
                                scale = 16'h1;
                            d.param = scale[7:0];
                        end
                        default: begin
                            mabs = q.maxv[15] ? 17'h0 : {1'b0, q.maxv};
                            if (q.minv[15]
                                && 17'(-$signed({1'b1, q.minv})) > mabs)
                                mabs = 17'(-$signed({1'b1, q.minv}));
                            for (int i = 1; i <= 7; i++) begin
                                if (mabs < (17'd1 << (15 - i)))
                                    e = 4'(i);
                            end
                            d.param = {q.width, e};
                        end
                    endcase
                end
                d.st = ST_CONV;
            end
            ST_CONV: begin
                d.obuf[q.cnt] = conv_out;
                d.cnt = q.cnt + 5'd1;
                if (q.cnt == LAST_WORD) begin
                    d.st = ST_IDLE;
                    d.done = 1'b1;
                    d.wr_idx = '0;
                    d.rd_idx = '0;
                end
            end
            default: ;
        endcase
        // --------------------------------------------------------
        // APB: read data latched in setup, effects in access
        // --------------------------------------------------------
        if (psel && !penable) begin
            d.slverr = 1'b0;
            d.prdata = '0;
            if (paddr == ADDR_CTRL) begin
                d.prdata[CTRL_METH_LSB +: 2] = q.meth;
                d.prdata[CTRL_DECOMP_BIT] = q.decomp;
                d.prdata[CTRL_WIDTH_LSB +: 4] = q.width;
            end else if (paddr == ADDR_PARAM) begin
                d.prdata[7:0] = q.param;
            end else if (paddr == ADDR_STATUS) begin
                d.prdata[STAT_BUSY_BIT] = q.st != ST_IDLE;
                d.prdata[STAT_DONE_BIT] = q.done;
                d.prdata[STAT_OVF_BIT] = q.ovf;
                d.prdata[STAT_WR_LSB +: 5] = q.wr_idx;
                d.prdata[STAT_RD_LSB +: 5] = q.rd_idx;
            end else if (paddr == ADDR_DATA) begin
                d.prdata = q.obuf[q.rd_idx];
            end else begin
                d.slverr = 1'b1;
            end
        end
        if (psel && penable && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                // Restarts the block, dropping anything in flight
                d.meth = pwdata[CTRL_METH_LSB +: 2];
                d.decomp = pwdata[CTRL_DECOMP_BIT];
                d.width = pwdata[CTRL_WIDTH_LSB +: 4];
                d.st = ST_IDLE;
                d.wr_idx = '0;
                d.rd_idx = '0;
                d.done = 1'b0;
                d.ovf = 1'b0;
            end else if (paddr == ADDR_PARAM) begin
                d.param = pwdata[7:0];
            end else if (paddr == ADDR_DATA) begin
                if (q.st == ST_IDLE && !q.done) begin
                    d.ibuf[q.wr_idx] = pwdata[15:0];
                    d.wr_idx = q.wr_idx + 5'd1;
                    if (q.wr_idx == LAST_WORD) begin
                        d.st = ST_SCAN;
                        d.cnt = '0;
                        d.maxv = 16'h8000;
                        d.minv = 16'h7fff;
                    end
                end else begin
                    d.ovf = 1'b1;
                end
            end
        end
        if (psel && penable && !pwrite && paddr == ADDR_DATA
            && q.done) begin
            // Draining the last word re-arms the input side
            d.rd_idx = q.rd_idx + 5'd1;
            if (q.rd_idx == LAST_WORD) begin
                d.rd_idx = '0;
                d.done = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pslverr = q.slverr & psel & penable;
    assign pready = 1'b1;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking dc @(posedge pclk iff ce);
    endclocking
    default disable iff (!presetn);

    a_bfp_exp_nibble: assert property (
        q.st == ST_PARAM && !q.decomp && q.meth == METH_BFP
        |=> q.param[7:4] == 4'h0 && q.st == ST_CONV)
        else $error("exponent exceeds four bits");
    a_bs_scale_range: assert property (
        q.st == ST_PARAM && !q.decomp && q.meth == METH_BS
        |=> q.param != 8'h0 && q.param <= SCALE_UNITY)
        else $error("scale factor out of range");
    a_mu_octet_form: assert property (
        q.st == ST_PARAM && !q.decomp && q.meth[1]
        |=> q.param[3:0] <= MU_SHIFT_MAX && q.param[7:4] == q.width)
        else $error("bad mu-law parameter octet");
    a_scan_block_len: assert property (
        $rose(q.st == ST_SCAN)
        |-> ##24 (q.st == ST_PARAM || q.st == ST_IDLE))
        else $error("scan did not span 24 words");
    a_conv_block_end: assert property (
        q.st == ST_PARAM |-> ##25 (q.st == ST_IDLE))
        else $error("conversion did not end after 24 words");
    a_comp_saturated: assert property (
        q.st == ST_CONV && !q.decomp
        |-> $signed(conv_out) >= -lim && $signed(conv_out) < lim)
        else $error("compressed value outside signed range");
    a_word_order: assert property (
        psel && penable && pwrite && paddr == ADDR_DATA
        && q.st == ST_IDLE && !q.done
        |=> q.ibuf[$past(q.wr_idx)] == $past(pwdata[15:0])
            && q.wr_idx == $past(q.wr_idx) + 5'd1
            || q.st == ST_SCAN)
        else $error("sample word stored out of order");
    a_done_after_conv: assert property (
        q.st == ST_CONV && q.cnt == LAST_WORD && !(psel && pwrite)
        |=> q.done && q.st == ST_IDLE)
        else $error("block not flagged done");
endmodule : fhc_codec
`default_nettype wire

// ===== hdl/fhc_pkg.sv
package fhc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PARAM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_METH_LSB = 0;
    localparam int CTRL_DECOMP_BIT = 2;
    localparam int CTRL_WIDTH_LSB = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_WR_LSB = 8;
    localparam int STAT_RD_LSB = 16;
    // ------------------------------------------------------------
    // Methods and block geometry
    // ------------------------------------------------------------
    localparam logic [1:0] METH_BFP = 2'h0;
    localparam logic [1:0] METH_BS = 2'h1;
    localparam logic [1:0] METH_MU = 2'h2;
    localparam int SUBCARRIERS = 12;
    localparam int BLOCK_WORDS = 2 * SUBCARRIERS;
    localparam logic [4:0] LAST_WORD = 5'h17;
    localparam logic [4:0] FULL_WIDTH = 5'h10;
    // ------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------
    localparam logic [16:0] MAG_MAX = 17'h07fff;
    localparam logic [16:0] MU_SEG1 = 17'h02000;
    localparam logic [16:0] MU_SEG2 = 17'h04000;
    localparam logic [3:0] MU_SHIFT_MAX = 4'h7;
    localparam logic [7:0] SCALE_UNITY = 8'h80;
    localparam logic [15:0] SCALE_ROUND = 16'h00ff;
    localparam int SCALE_SHIFT = 8;
    localparam int BS_DEC_BIAS = 9;
    localparam logic signed [39:0] MU_SUB2 = 40'sh0000002000;
    localparam logic signed [39:0] MU_SUB3 = 40'sh0000008000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SCAN,
        ST_PARAM,
        ST_CONV
    } fhc_state_t;

    typedef struct packed {
        fhc_state_t st;
        logic [BLOCK_WORDS-1:0][15:0] ibuf;
        logic [BLOCK_WORDS-1:0][31:0] obuf;
        logic [4:0] wr_idx;
        logic [4:0] rd_idx;
        logic [4:0] cnt;
        logic [15:0] maxv;
        logic [15:0] minv;
        logic [1:0] meth;
        logic decomp;
        logic [3:0] width;
        logic [7:0] param;
        logic done;
        logic ovf;
        logic [31:0] prdata;
        logic slverr;
    } fhc_regs_t;
endpackage : fhc_pkg

// ===== sim/fhc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module fhc_peer
    import fhc_pkg::*;
(
    // Block setup
    input wire logic [7:0] ctrl,
    input wire logic [7:0] param_in,
    input wire logic signed [15:0] blk [BLOCK_WORDS],
    // Expected results
    output logic [31:0] exp_word [BLOCK_WORDS],
    output logic [7:0] exp_param
);
    // ------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------
    // Half-up rounding of a right shift; negative ties round upwards
    // A negative shift count scales up instead, with nothing to round
    function automatic int rnd(input int v, input int k);
        return (k < 0) ? (v <<< -k)
            : (k == 0) ? v : ((v + (1 <<< (k - 1))) >>> k);
    endfunction : rnd

    function automatic int sat(input int v, input int w);
        int hi;
        hi = (1 << (w - 1)) - 1;
        return (v > hi) ? hi : ((v < -hi - 1) ? -hi - 1 : v);
    endfunction : sat

    function automatic int mag(input int v);
        return (v < 0) ? -v : v;
    endfunction : mag

    // ------------------------------------------------------------
    // Peer codec: what the far end computes for the same block
    // ------------------------------------------------------------
    always_comb begin : model
        int w, e, sh, mx, mn, am, s, inv, a, c, x;
        w = (ctrl[7:4] == 4'h0) ? 16 : int'(ctrl[7:4]);
        mx = -32768;
        mn = 32767;
        am = 0;
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            x = int'(blk[i]);
            mx = (x > mx) ? x : mx;
            mn = (x < mn) ? x : mn;
            am = (mag(x) > am) ? mag(x) : am;
        end
        e = 0;
        while (e < 15 && (sat(mx >>> e, w) != (mx >>> e)
                || sat(mn >>> e, w) != (mn >>> e))) begin
            e++;
        end
        a = (mx > mag(mn) - 1) ? mx : mag(mn) - 1;
        s = (a + 255) / 256;
        s = (s == 0) ? 1 : s;
        inv = 128 / s;
        sh = 0;
        while (sh < 7 && (am << sh) < 16384) begin
            sh++;
        end
        case (ctrl[1:0])
            METH_BFP: exp_param = 8'(e);
            METH_BS: exp_param = 8'(s);
            default: exp_param = {ctrl[7:4], 4'(sh)};
        endcase
        s = ctrl[2] ? int'(param_in) : s;
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            x = int'(blk[i]);
            if (ctrl[1:0] == METH_BFP) begin
                c = ctrl[2] ? (x <<< param_in[3:0]) : sat(rnd(x, e), w);
            end else if (ctrl[1:0] == METH_BS) begin
                c = ctrl[2] ? rnd(s * x, w - 9)
                    : sat(rnd(inv * x, 16 - w), w);
            end else if (!ctrl[2]) begin
                a = mag(x) << sh;
                a = (a > 32767) ? 32767 : a;
                c = (a <= 8192) ? rnd(a, 15 - w)
                    : (a <= 16384) ? rnd(a, 16 - w) + (1 << (w - 3))
                    : rnd(a, 17 - w) + (1 << (w - 2));
                c = sat((x < 0) ? -c : c, w);
            end else begin
                a = mag(x);
                a = (a > (1 << (w - 1)) - 1) ? (1 << (w - 1)) - 1 : a;
                c = (a <= (1 << (w - 2))) ? (a << (15 - w))
                    : (a <= (1 << (w - 2)) + (1 << (w - 3)))
                    ? (a << (16 - w)) - 8192 : (a << (17 - w)) - 32768;
                c = ((x < 0) ? -c : c) >>> param_in[3:0];
            end
            exp_word[i] = 32'(c);
        end
    end
endmodule : fhc_peer
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import fhc_pkg::*;
;
    localparam int CYCLE_LIMIT = 10000;
    localparam logic [31:0] DONE_M = 32'h1 << STAT_DONE_BIT;
    localparam logic [31:0] OVF_M = 32'h1 << STAT_OVF_BIT;
    localparam logic [31:0] BUSY_M = 32'h1 << STAT_BUSY_BIT;
    // Mode table: {width, decompress, method}, parameter, amplitude
    localparam logic [7:0] CTRL_TAB [9] = '{8'h80, 8'h80, 8'h84, 8'h91,
        8'h01, 8'hc5, 8'h82, 8'h83, 8'h86};
    localparam logic [7:0] PAR_TAB [9] = '{8'h00, 8'h00, 8'h05, 8'h00,
        8'h00, 8'h64, 8'h00, 8'h00, 8'h83};
    // Amplitudes avoid exact rounding ties in the compress cases
    localparam int AMP_TAB [9] = '{301, 7, 4, 1001, 2000, 100, 4, 1024, 9};
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, ctrl_r, par_r, exp_param;
    logic [31:0] pwdata, prdata, rd_d;
    logic rd_e;
    logic signed [15:0] blk [BLOCK_WORDS];
    logic [31:0] exp_word [BLOCK_WORDS];
    int err_count, tests_run, cycles;

    fhc_codec uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fhc_peer peer (.ctrl(ctrl_r), .param_in(par_r), .blk(blk),
        .exp_word(exp_word), .exp_param(exp_param));

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Data and error are taken at the edge that sees pready high
        do @(posedge pclk); while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // One block through the codec, compared word by word with the peer
    task automatic run_block(input int n);
        int k;
        ctrl_r = CTRL_TAB[n];
        par_r = PAR_TAB[n];
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            blk[i] = 16'(((i * 37) % 29 - 14) * AMP_TAB[n]);
        end
        apb_xfer(1'b1, ADDR_CTRL, {24'h0, ctrl_r});
        if (ctrl_r[2]) begin
            apb_xfer(1'b1, ADDR_PARAM, {24'h0, par_r});
        end
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            apb_xfer(1'b1, ADDR_DATA, {16'h0, blk[i]});
        end
        if (n == 3) begin
            // Freeze for longer than a whole block: it must not finish
            @(posedge pclk);
            ce <= 1'b0;
            repeat (60) @(posedge pclk);
            ce <= 1'b1;
            apb_xfer(1'b0, ADDR_STATUS, 32'h0);
            chk(rd_d & (DONE_M | BUSY_M), BUSY_M);
        end
        k = 0;
        rd_d = 32'h0;
        while (rd_d[STAT_DONE_BIT] !== 1'b1 && k < 100) begin
            apb_xfer(1'b0, ADDR_STATUS, 32'h0);
            k++;
        end
        chk(rd_d, DONE_M);
        // A word pushed while results wait is dropped and flagged
        apb_xfer(1'b1, ADDR_DATA, 32'h0000_7fff);
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_d, DONE_M | OVF_M);
        if (!ctrl_r[2]) begin
            apb_xfer(1'b0, ADDR_PARAM, 32'h0);
            chk({24'h0, rd_d[7:0]}, {24'h0, exp_param});
        end
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            apb_xfer(1'b0, ADDR_DATA, 32'h0);
            chk(rd_d, exp_word[i]);
        end
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_d, OVF_M);
        $display("Block test %0d ctrl %h done", n, ctrl_r);
    endtask : run_block

    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ctrl_r = 8'h00;
        par_r = 8'h00;
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb_xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_d, 32'h0);
        apb_xfer(1'b0, 8'h10, 32'h0);
        chk(rd_d, 32'h0);
        chk({31'h0, rd_e}, 32'h1);
        $display("Reset and unmapped access test done");
        for (int n = 0; n < 9; n++) begin
            run_block(n);
        end
        close_out();
    end
endmodule : testbench
`default_nettype wire
